// ---- common/tbss_defs.vh ----
`ifndef TBSS_DEFS_VH
`define TBSS_DEFS_VH
// =============================================================
// Register map (word index = byte address / 4 not used here).
`define TBSS_A_CTRL      4'h0
`define TBSS_A_TRIGCNT   4'h1
`define TBSS_A_DELAY     4'h2
`define TBSS_A_BURST     4'h3
`define TBSS_A_INTERVAL  4'h4
`define TBSS_A_CHANS     4'h5
`define TBSS_A_WINDOW    4'h6
`define TBSS_A_STATUS    4'h7
`define TBSS_A_CMD       4'h8
`define TBSS_A_RDATA     4'h9
`define TBSS_A_MEMCNT    4'ha
// CTRL fields.
`define TBSS_C_SRC_LO    0
`define TBSS_C_SRC_HI    1
`define TBSS_C_ORIGIN    2
`define TBSS_C_AZERO     3
`define TBSS_C_SSMUX     4
`define TBSS_C_MAINS50   5
// CMD bits.
`define TBSS_K_CONF      0
`define TBSS_K_ARM       1
`define TBSS_K_ARMRET    2
`define TBSS_K_BUSTRIG   3
`define TBSS_K_COLLECT   4
`define TBSS_K_ABORT     5
// Trigger sources.
`define TBSS_SRC_IMM     2'h0
`define TBSS_SRC_EXT     2'h1
`define TBSS_SRC_BUS     2'h2
`define TBSS_SRC_HOLD    2'h3
// Window codes.
`define TBSS_WIN_16M7    3'h3
`define TBSS_WIN_20M     3'h4
// Reset values and limits.
`define TBSS_MAX_COUNT   24'hffffff
`define TBSS_MAX_DELAY_S 16.7
`define TBSS_RDG_BYTES   4
`define TBSS_MIN_INTERVAL 24'h000001
`endif

// ---- rtl/tbss_fifo.v ----
// =============================================================
// Small synchronous FIFO with valid/ready on both sides.
module tbss_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_r;
    reg [AW-1:0]    rp_r;
    reg [AW:0]      cnt_r;
    wire            push;
    wire            pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (cnt_r != DEPTH);
    assign out_valid = (cnt_r != 0);
    assign out_data  = mem[rp_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers wrap at the depth; depth need not be a power of two.
    always @(posedge clk) begin
        if (rst) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wp_r] <= in_data;
                wp_r <= (wp_r == DEPTH-1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (pop)
                rp_r <= (rp_r == DEPTH-1) ? {AW{1'b0}} : rp_r + 1'b1;
            if (push & ~pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop & ~push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // tbss_fifo

// ---- rtl/tbss_seq.v ----
`include "tbss_defs.vh"

module tbss_seq #(
    parameter CLK_HZ   = 10000000,
    parameter MEM_AW   = 8,
    parameter OBUF_D   = 8,
    parameter FIFO_D   = 4,
    parameter AZ_GAP   = 16
) (
    input  wire        MCLK,
    input  wire        SRST,
    input  wire [3:0]  ADDR,
    input  wire [31:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [31:0] RDATA,
    input  wire        EXT_TRIG_N,
    output reg         MEAS_START,
    input  wire        MEAS_DONE,
    input  wire [31:0] MEAS_DATA,
    output reg  [7:0]  MUX_CHAN,
    output reg         MUX_ADVANCE,
    output reg         MEAS_AZERO,
    output reg  [2:0]  MEAS_WINDOW
);
    // =========================================================
    // States.
    localparam S_IDLE  = 3'h0;
    localparam S_WAIT  = 3'h1;
    localparam S_DELAY = 3'h2;
    localparam S_START = 3'h3;
    localparam S_MEAS  = 3'h4;
    localparam S_GAP   = 3'h5;
    localparam S_DRAIN = 3'h6;
    // Delay and interval registers count in microseconds.
    localparam TICK_US = CLK_HZ / 1000000;
    localparam [23:0] DLY_MAX_US = 24'd16700000;
    localparam MEMD = 1 << MEM_AW;

    // =========================================================
    // Configuration registers.
    reg  [23:0] trig_repeat_count_r;
    reg  [23:0] trigger_to_burst_delay_r;
    reg  [23:0] burst_reading_count_r;
    reg  [23:0] reading_interval_r;
    reg  [7:0]  chan_count_r;
    reg  [2:0]  integration_window_r;
    reg  [1:0]  trigger_origin_select_r;
    reg         interval_origin_select_r;
    reg         azero_r;
    reg         ssmux_r;
    reg         mains50_r;
    reg         to_mem_r;
    reg         collect_r;

    // Sequencer state.
    reg  [2:0]  state_r;
    reg  [23:0] trig_left_r;
    reg  [23:0] rdg_left_r;
    reg  [23:0] timer_r;
    reg  [3:0]  tick_r;
    reg         bus_trig_r;
    reg         ext_s1_r;
    reg         ext_s2_r;
    reg         ext_s3_r;

    // Bulk memory and output buffer.
    reg  [31:0]       mem [0:MEMD-1];
    reg  [MEM_AW:0]   mem_wp_r;
    reg  [MEM_AW:0]   mem_rp_r;
    reg  [31:0]       obuf [0:OBUF_D-1];
    reg  [2:0]        ob_wp_r;
    reg  [2:0]        ob_rp_r;
    reg  [3:0]        ob_cnt_r;

    wire        cmd = WR & (ADDR == `TBSS_A_CMD);
    wire        ext_fall = ext_s3_r & ~ext_s2_r;
    wire        f_valid;
    wire        f_ready;
    wire [31:0] f_data;
    wire        ob_full = (ob_cnt_r == OBUF_D);
    wire        ob_pop = RD & (ADDR == `TBSS_A_RDATA) & (ob_cnt_r != 0);
    wire        mem_full = (mem_wp_r == MEMD);
    wire        coll_push = collect_r & (mem_rp_r != mem_wp_r) & ~ob_full
                            & ~(f_valid & ~to_mem_r);
    // Sink accepts FIFO words into memory or the output buffer.
    wire        sink_rdy = to_mem_r ? ~mem_full : ~ob_full;
    wire        f_pop = f_valid & sink_rdy;
    wire        ob_push = (f_pop & ~to_mem_r) | coll_push;
    wire        multi = (chan_count_r > 8'h01);
    wire        trig_hit;
    wire        gap_zero;

    // Trigger qualifier by source.
    assign trig_hit =
        (trigger_origin_select_r == `TBSS_SRC_IMM) ? 1'b1 :
        (trigger_origin_select_r == `TBSS_SRC_EXT) ? ext_fall :
        (trigger_origin_select_r == `TBSS_SRC_BUS) ? bus_trig_r :
        1'b0;
    // Spacing disabled across scan channels without solid-state mux.
    assign gap_zero = (multi & ~ssmux_r) | ~interval_origin_select_r;

    // The FIFO decouples the converter from storage; a stall there
    // holds off the next conversion start.
    tbss_fifo #(.WIDTH(32), .DEPTH(FIFO_D), .AW(2)) u_fifo (
        .clk       (MCLK),
        .rst       (SRST),
        .in_valid  (MEAS_DONE),
        .in_ready  (f_ready),
        .in_data   (MEAS_DATA),
        .out_valid (f_valid),
        .out_ready (sink_rdy),
        .out_data  (f_data)
    );

    // =========================================================
    // External trigger synchroniser and edge stage.
    always @(posedge MCLK) begin
        if (SRST) begin
            ext_s1_r <= 1'b1;
            ext_s2_r <= 1'b1;
            ext_s3_r <= 1'b1;
        end else begin
            ext_s1_r <= EXT_TRIG_N;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // =========================================================
    // Register writes and configure defaults.
    always @(posedge MCLK) begin
        if (SRST | (cmd & WDATA[`TBSS_K_CONF])) begin
            trig_repeat_count_r      <= 24'h000001;
            trigger_to_burst_delay_r <= 24'h000000;
            burst_reading_count_r    <= 24'h000001;
            reading_interval_r       <= `TBSS_MIN_INTERVAL;
            interval_origin_select_r <= 1'b0;
            azero_r                  <= 1'b1;
            trigger_origin_select_r  <= `TBSS_SRC_IMM;
            integration_window_r     <= (mains50_r & ~SRST) ? `TBSS_WIN_20M
                                                  : `TBSS_WIN_16M7;
            if (SRST) begin
                chan_count_r <= 8'h00;
                ssmux_r      <= 1'b0;
                mains50_r    <= 1'b0;
            end
        end else if (WR) begin
            case (ADDR)
                `TBSS_A_CTRL: begin
                    trigger_origin_select_r  <= WDATA[1:0];
                    interval_origin_select_r <= WDATA[`TBSS_C_ORIGIN];
                    azero_r                  <= WDATA[`TBSS_C_AZERO];
                    ssmux_r                  <= WDATA[`TBSS_C_SSMUX];
                    mains50_r                <= WDATA[`TBSS_C_MAINS50];
                end
                `TBSS_A_TRIGCNT:
                    trig_repeat_count_r <= (WDATA[23:0] == 24'h0) ?
                        24'h000001 : WDATA[23:0];
                `TBSS_A_DELAY:
                    trigger_to_burst_delay_r <=
                        (WDATA[23:0] > DLY_MAX_US) ? DLY_MAX_US
                                                   : WDATA[23:0];
                `TBSS_A_BURST:
                    burst_reading_count_r <= (WDATA[23:0] == 24'h0) ?
                        24'h000001 : WDATA[23:0];
                `TBSS_A_INTERVAL:
                    reading_interval_r <= WDATA[23:0];
                `TBSS_A_CHANS:  chan_count_r <= WDATA[7:0];
                `TBSS_A_WINDOW: integration_window_r <= WDATA[2:0];
                default: begin
                end
            endcase
        end
    end

    // =========================================================
    // Sequencer: wait, delay, start, measure, gap, then drain.
    always @(posedge MCLK) begin
        if (SRST) begin
            state_r     <= S_IDLE;
            trig_left_r <= 24'h0;
            rdg_left_r  <= 24'h0;
            timer_r     <= 24'h0;
            tick_r      <= 4'h0;
            bus_trig_r  <= 1'b0;
            to_mem_r    <= 1'b0;
            MEAS_START  <= 1'b0;
            MUX_CHAN    <= 8'h00;
            MUX_ADVANCE <= 1'b0;
        end else begin
            MEAS_START  <= 1'b0;
            MUX_ADVANCE <= 1'b0;
            // Bus triggers only count while waiting.
            bus_trig_r  <= cmd & WDATA[`TBSS_K_BUSTRIG]
                           & (state_r == S_WAIT);
            tick_r <= (tick_r == TICK_US - 1) ? 4'h0 : tick_r + 1'b1;
            if (cmd & (WDATA[`TBSS_K_ABORT] | WDATA[`TBSS_K_CONF])) begin
                state_r <= S_IDLE;
            end else begin
                case (state_r)
                    S_IDLE: begin
                        if (cmd & (WDATA[`TBSS_K_ARM]
                                   | WDATA[`TBSS_K_ARMRET])) begin
                            to_mem_r    <= ~WDATA[`TBSS_K_ARMRET];
                            trig_left_r <= trig_repeat_count_r;
                            state_r     <= S_WAIT;
                        end
                    end
                    S_WAIT: begin
                        // One trigger begins one burst or pass.
                        if (trig_hit) begin
                            trig_left_r <= trig_left_r - 1'b1;
                            timer_r     <= trigger_to_burst_delay_r;
                            rdg_left_r  <= multi ? {16'h0, chan_count_r}
                                                 : burst_reading_count_r;
                            MUX_CHAN    <= 8'h00;
                            tick_r      <= 4'h0;
                            state_r     <= S_DELAY;
                        end
                    end
                    S_DELAY: begin
                        // Delay only ahead of the first reading.
                        if (timer_r == 24'h0)
                            state_r <= S_START;
                        else if (tick_r == TICK_US - 1)
                            timer_r <= timer_r - 1'b1;
                    end
                    S_START: begin
                        // Hold off starts while the path is backed up.
                        if (f_ready & ~(ob_full & ~to_mem_r)) begin
                            MEAS_START <= 1'b1;
                            state_r    <= S_MEAS;
                        end
                    end
                    S_MEAS: begin
                        if (MEAS_DONE) begin
                            rdg_left_r <= rdg_left_r - 1'b1;
                            // Autozero adds a settle gap between readings.
                            timer_r <= (gap_zero ? 24'h0 : reading_interval_r)
                                + (azero_r ? AZ_GAP[23:0] : 24'h0);
                            tick_r  <= 4'h0;
                            state_r <= S_GAP;
                        end
                    end
                    S_GAP: begin
                        if (rdg_left_r == 24'h0) begin
                            state_r <= (trig_left_r == 24'h0) ? S_DRAIN
                                                              : S_WAIT;
                        end else if (timer_r == 24'h0) begin
                            if (multi) begin
                                MUX_CHAN    <= MUX_CHAN + 1'b1;
                                MUX_ADVANCE <= 1'b1;
                            end
                            state_r <= S_START;
                        end else if (tick_r == TICK_US - 1)
                            timer_r <= timer_r - 1'b1;
                    end
                    S_DRAIN: begin
                        if (~f_valid)
                            state_r <= S_IDLE;
                    end
                    default: state_r <= S_IDLE;
                endcase
            end
        end
    end

    // =========================================================
    // Bulk memory and output buffer; collect only once idle.
    always @(posedge MCLK) begin
        if (SRST) begin
            mem_wp_r  <= {(MEM_AW+1){1'b0}};
            mem_rp_r  <= {(MEM_AW+1){1'b0}};
            ob_wp_r   <= 3'h0;
            ob_rp_r   <= 3'h0;
            ob_cnt_r  <= 4'h0;
            collect_r <= 1'b0;
        end else begin
            if (cmd & (WDATA[`TBSS_K_ARM] | WDATA[`TBSS_K_ARMRET])
                & (state_r == S_IDLE)) begin
                mem_wp_r <= {(MEM_AW+1){1'b0}};
                mem_rp_r <= {(MEM_AW+1){1'b0}};
            end else begin
                if (f_pop & to_mem_r) begin
                    mem[mem_wp_r[MEM_AW-1:0]] <= f_data;
                    mem_wp_r <= mem_wp_r + 1'b1;
                end
                if (coll_push)
                    mem_rp_r <= mem_rp_r + 1'b1;
            end
            if (cmd & WDATA[`TBSS_K_COLLECT] & (state_r == S_IDLE))
                collect_r <= 1'b1;
            else if (mem_rp_r == mem_wp_r)
                collect_r <= 1'b0;
            if (ob_push) begin
                obuf[ob_wp_r] <= coll_push ? mem[mem_rp_r[MEM_AW-1:0]]
                                           : f_data;
                ob_wp_r <= ob_wp_r + 1'b1;
            end
            if (ob_pop)
                ob_rp_r <= ob_rp_r + 1'b1;
            if (ob_push & ~ob_pop)
                ob_cnt_r <= ob_cnt_r + 1'b1;
            else if (ob_pop & ~ob_push)
                ob_cnt_r <= ob_cnt_r - 1'b1;
        end
    end

    // =========================================================
    // Read port and front-end outputs.
    always @(posedge MCLK) begin
        if (SRST) begin
            RDATA       <= 32'h0;
            MEAS_AZERO  <= 1'b1;
            MEAS_WINDOW <= `TBSS_WIN_16M7;
        end else begin
            MEAS_AZERO  <= azero_r;
            MEAS_WINDOW <= integration_window_r;
            RDATA       <= 32'h0;
            if (RD) begin
                case (ADDR)
                    `TBSS_A_CTRL: RDATA <= {26'h0, mains50_r, ssmux_r,
                        azero_r, interval_origin_select_r,
                        trigger_origin_select_r};
                    `TBSS_A_TRIGCNT:  RDATA <= {8'h0, trig_repeat_count_r};
                    `TBSS_A_DELAY:    RDATA <= {8'h0, trigger_to_burst_delay_r};
                    `TBSS_A_BURST:    RDATA <= {8'h0, burst_reading_count_r};
                    `TBSS_A_INTERVAL: RDATA <= {8'h0, reading_interval_r};
                    `TBSS_A_CHANS:    RDATA <= {24'h0, chan_count_r};
                    `TBSS_A_WINDOW:   RDATA <= {29'h0, integration_window_r};
                    `TBSS_A_STATUS:   RDATA <= {20'h0, ob_cnt_r, 1'b0,
                        collect_r, to_mem_r, state_r, f_valid, ob_full};
                    `TBSS_A_RDATA:
                        RDATA <= (ob_cnt_r != 0) ? obuf[ob_rp_r] : 32'h0;
                    `TBSS_A_MEMCNT:   // Byte count: four per reading.
                        RDATA <= {{(31-MEM_AW-2){1'b0}}, mem_wp_r, 2'b00};
                    default: RDATA <= 32'h0;
                endcase
            end
        end
    end
endmodule // tbss_seq

// ---- tb/tbss_meas_model.sv ----
// ============================================================
// Measurement front end that answers each conversion request.
module tbss_meas_model (
    input  wire logic        clk,
    input  wire logic        start,
    input  wire logic [7:0]  chan,
    output logic             done,
    output logic [31:0]      data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] seq = 24'h0;
    logic [7:0]  chan_r = 8'h0;
    int          cnt = 0;
    initial done = 1'b0;
    initial data = 32'h0;

    // Latency alternates 2 and 6 cycles; data toggles while not valid,
    // so a reading taken in the wrong cycle never matches by chance.
    always @(posedge clk) begin
        done <= 1'b0;
        data <= ~data;
        if (start) begin
            cnt    <= seq[0] ? 6 : 2;
            chan_r <= chan;
        end else if (cnt == 1) begin
            done <= 1'b1;
            data <= {chan_r, seq};
            seq  <= seq + 24'h1;
        end
        if (!start && cnt > 0) cnt <= cnt - 1;
    end
endmodule // tbss_meas_model

// ---- tb/tbss_seq_sva.sv ----
`include "tbss_defs.vh"
// ============================================================
// Port-level checks on the trigger and burst sequencer.
module tbss_seq_sva (
    input wire logic        MCLK,
    input wire logic        SRST,
    input wire logic [3:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        EXT_TRIG_N,
    input wire logic        MEAS_START,
    input wire logic        MEAS_DONE,
    input wire logic [31:0] MEAS_DATA,
    input wire logic [7:0]  MUX_CHAN,
    input wire logic        MUX_ADVANCE,
    input wire logic        MEAS_AZERO,
    input wire logic [2:0]  MEAS_WINDOW
);
    logic       busy_r;
    logic       mains_r;
    logic [2:0] win_r;
    wire        cmd_wr = WR && ADDR == `TBSS_A_CMD;
    wire        ctl_wr = WR && ADDR == `TBSS_A_CTRL;
    wire        win_wr = WR && ADDR == `TBSS_A_WINDOW;
    wire        conf_wr = cmd_wr && WDATA[`TBSS_K_CONF];

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    // Track an open conversion; an abort may strand one, so it clears.
    always @(posedge MCLK) begin
        if (SRST || (cmd_wr && WDATA[`TBSS_K_ABORT]))
            busy_r <= 1'b0;
        else if (MEAS_START)
            busy_r <= 1'b1;
        else if (MEAS_DONE)
            busy_r <= 1'b0;
    end

    // Remember the mains bit and the last window code written.
    always @(posedge MCLK) begin
        if (SRST) begin
            mains_r <= 1'b0;
            win_r   <= `TBSS_WIN_16M7;
        end else begin
            if (ctl_wr) mains_r <= WDATA[`TBSS_C_MAINS50];
            if (win_wr) win_r <= WDATA[2:0];
        end
    end

    a_start_pulse: assert property (MEAS_START |=> !MEAS_START)
        else $error("conversion start held over one cycle");
    a_one_open: assert property (MEAS_START |-> !busy_r)
        else $error("conversion started before the last one ended");
    a_reset_outputs: assert property ($fell(SRST) |->
        MEAS_AZERO && MEAS_WINDOW == `TBSS_WIN_16M7 && MUX_CHAN == 8'h0)
        else $error("outputs wrong after reset");
    a_chan_step: assert property ($changed(MUX_CHAN) |->
        MUX_CHAN == 8'h0 || MUX_CHAN == $past(MUX_CHAN) + 8'h1)
        else $error("channel index skipped");
    a_advance_pulse: assert property (MUX_ADVANCE |=> !MUX_ADVANCE)
        else $error("channel advance held over one cycle");
    a_conf_azero: assert property (conf_wr |-> ##[1:3] MEAS_AZERO)
        else $error("configure left autozero off");
    a_conf_window: assert property (conf_wr |-> ##[1:3]
        MEAS_WINDOW == (mains_r ? `TBSS_WIN_20M : `TBSS_WIN_16M7))
        else $error("configure chose the wrong window");
    a_azero_off: assert property (
        ctl_wr && !WDATA[`TBSS_C_AZERO] |-> ##[1:3] !MEAS_AZERO)
        else $error("autozero stayed on");
    a_window_set: assert property (win_wr |-> ##2 MEAS_WINDOW == win_r)
        else $error("window code not applied");
endmodule // tbss_seq_sva

bind tbss_seq tbss_seq_sva tbss_seq_sva_i (.MCLK(MCLK), .SRST(SRST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .EXT_TRIG_N(EXT_TRIG_N), .MEAS_START(MEAS_START),
    .MEAS_DONE(MEAS_DONE), .MEAS_DATA(MEAS_DATA), .MUX_CHAN(MUX_CHAN),
    .MUX_ADVANCE(MUX_ADVANCE), .MEAS_AZERO(MEAS_AZERO),
    .MEAS_WINDOW(MEAS_WINDOW));

// ---- tb/tbss_seq_tb_top.sv ----
`include "tbss_defs.vh"
// ============================================================
// Register-driven tests of the trigger and burst sequencer.
module tbss_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        MCLK = 1'b0;
    logic        SRST = 1'b1;
    logic [3:0]  ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic        EXT_TRIG_N = 1'b1;
    wire  [31:0] RDATA, MEAS_DATA;
    wire  [7:0]  MUX_CHAN;
    wire  [2:0]  MEAS_WINDOW;
    wire         MEAS_START, MEAS_DONE, MUX_ADVANCE, MEAS_AZERO;
    int          errors = 0;
    int          n_compared = 0;
    int          n_start = 0;
    int          n_adv = 0;
    int          cyc = 0;
    int          t_last = 0;
    int          t_first = 0;
    int          gap = 0;
    int          base, tt, i;
    logic [23:0] seq_exp = 24'h0;
    logic [31:0] v;
    logic [3:0]  def_a [4] = '{`TBSS_A_TRIGCNT, `TBSS_A_DELAY,
                              `TBSS_A_BURST, `TBSS_A_INTERVAL};
    logic [31:0] def_v [4] = '{32'h1, 32'h0, 32'h1,
                              {8'h0, `TBSS_MIN_INTERVAL}};

    // A short autozero gap keeps the run brief without changing order.
    tbss_seq #(.AZ_GAP(2)) tbss_seq_i (.MCLK(MCLK), .SRST(SRST),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .EXT_TRIG_N(EXT_TRIG_N), .MEAS_START(MEAS_START),
        .MEAS_DONE(MEAS_DONE), .MEAS_DATA(MEAS_DATA),
        .MUX_CHAN(MUX_CHAN), .MUX_ADVANCE(MUX_ADVANCE),
        .MEAS_AZERO(MEAS_AZERO), .MEAS_WINDOW(MEAS_WINDOW));
    tbss_meas_model tbss_meas_model_i (.clk(MCLK), .start(MEAS_START),
        .chan(MUX_CHAN), .done(MEAS_DONE), .data(MEAS_DATA));

    initial forever #50 MCLK = ~MCLK;

    // Count starts and advances, note spacing, and cut a hang short.
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (MUX_ADVANCE === 1'b1) n_adv <= n_adv + 1;
        if (MEAS_START === 1'b1) begin
            n_start <= n_start + 1;
            gap     <= cyc - t_last;
            t_last  <= cyc;
            if (t_first == 0) t_first <= cyc;
        end
        if (cyc == 30000) begin
            errors = errors + 1;
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge MCLK);
        WR    <= 1'b1;
        ADDR  <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge MCLK);
        RD   <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
        @(negedge MCLK);
        d = RDATA;
    endtask

    task automatic cmd(input int b);
        wr(`TBSS_A_CMD, 32'h1 << b);
    endtask

    task automatic idle_wait();
        int k;
        for (k = 0; k < 300; k++) begin
            rd(`TBSS_A_STATUS, v);
            if (v[4:2] === 3'h0) break;
        end
        chk(32'(v[4:2]), 32'h0);
    endtask

    // Readings arrive in conversion order tagged with their channel.
    task automatic rdgs(input int n, input int nch);
        int k;
        for (k = 0; k < n; k++) begin
            rd(`TBSS_A_RDATA, v);
            chk(v, {8'(k % nch), seq_exp});
            seq_exp = seq_exp + 24'h1;
        end
    endtask

    task automatic ext_pulse();
        @(posedge MCLK);
        EXT_TRIG_N <= 1'b0;
        repeat (3) @(posedge MCLK);
        EXT_TRIG_N <= 1'b1;
        repeat (3) @(posedge MCLK);
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge MCLK);
        SRST <= 1'b0;
        // Configure keeps the mains bit, ss mux bit and channel count and restores the other defaults.
        wr(`TBSS_A_CTRL, 32'h20);
        cmd(`TBSS_K_CONF);
        rd(`TBSS_A_CTRL, v);
        chk(v, 32'h28);
        chk(32'(MEAS_WINDOW), 32'(`TBSS_WIN_20M));
        for (i = 0; i < 4; i++) begin
            rd(def_a[i], v);
            chk(v, def_v[i]);
        end
        wr(`TBSS_A_TRIGCNT, 32'h00ffffff);
        rd(`TBSS_A_TRIGCNT, v);
        chk(v, 32'h00ffffff);
        wr(`TBSS_A_DELAY, 32'hffffffff);
        rd(`TBSS_A_DELAY, v);
        chk(v, 32'h00fed260);
        rd(4'hf, v);
        chk(v, 32'h0);
        wr(`TBSS_A_WINDOW, 32'h1);
        repeat (3) @(posedge MCLK);
        chk(32'(MEAS_WINDOW), 32'h1);
        $display("test registers done");
        // Immediate burst into the output buffer until it stalls.
        cmd(`TBSS_K_CONF);
        wr(`TBSS_A_CTRL, 32'h0);
        wr(`TBSS_A_BURST, 32'he);
        base = n_start;
        cmd(`TBSS_K_ARMRET);
        repeat (300) @(posedge MCLK);
        rd(`TBSS_A_STATUS, v);
        chk(32'(v[0]), 32'h1);
        chk(32'(v[11:8]), 32'h8);
        chk(32'(n_start - base < 14), 32'h1);
        rdgs(8, 1);
        repeat (200) @(posedge MCLK);
        rdgs(6, 1);
        chk(32'(n_start - base), 32'he);
        idle_wait();
        $display("test direct burst done");
        // Two paced bursts to memory, then collected.
        wr(`TBSS_A_TRIGCNT, 32'h2);
        wr(`TBSS_A_BURST, 32'h2);
        wr(`TBSS_A_INTERVAL, 32'h3);
        wr(`TBSS_A_CTRL, 32'h4);
        base = n_start;
        cmd(`TBSS_K_ARM);
        idle_wait();
        chk(32'(n_start - base), 32'h4);
        chk(32'(gap >= 30), 32'h1);
        rd(`TBSS_A_MEMCNT, v);
        chk(v, 32'h10);
        rd(`TBSS_A_STATUS, v);
        chk(32'(v[11:8]), 32'h0);
        cmd(`TBSS_K_COLLECT);
        idle_wait();
        rdgs(4, 1);
        $display("test memory burst done");
        // Externally triggered scans; a second edge during the delay
        // must be ignored, and no interval applies without ss mux.
        wr(`TBSS_A_CTRL, 32'h5);
        wr(`TBSS_A_CHANS, 32'h3);
        wr(`TBSS_A_DELAY, 32'h2);
        wr(`TBSS_A_BURST, 32'h5);
        base = n_start;
        cmd(`TBSS_K_ARMRET);
        repeat (50) @(posedge MCLK);
        chk(32'(n_start - base), 32'h0);
        tt = cyc;
        t_first = 0;
        ext_pulse();
        ext_pulse();
        repeat (150) @(posedge MCLK);
        chk(32'(n_start - base), 32'h3);
        chk(32'(t_first - tt >= 20), 32'h1);
        chk(32'(gap < 20), 32'h1);
        tt = n_adv;
        ext_pulse();
        repeat (150) @(posedge MCLK);
        chk(32'(n_start - base), 32'h6);
        chk(32'(n_adv - tt), 32'h2);
        rdgs(6, 3);
        idle_wait();
        $display("test external scan done");
        // Bus trigger counts only while waiting; hold never fires.
        wr(`TBSS_A_CHANS, 32'h1);
        wr(`TBSS_A_CTRL, 32'h2);
        wr(`TBSS_A_TRIGCNT, 32'h1);
        wr(`TBSS_A_DELAY, 32'h0);
        base = n_start;
        cmd(`TBSS_K_BUSTRIG);
        cmd(`TBSS_K_ARMRET);
        repeat (50) @(posedge MCLK);
        chk(32'(n_start - base), 32'h0);
        cmd(`TBSS_K_BUSTRIG);
        repeat (50) @(posedge MCLK);
        chk(32'(n_start - base), 32'h5);
        rdgs(5, 1);
        wr(`TBSS_A_CTRL, 32'h3);
        cmd(`TBSS_K_ARMRET);
        repeat (50) @(posedge MCLK);
        chk(32'(n_start - base), 32'h5);
        cmd(`TBSS_K_ABORT);
        idle_wait();
        $display("test bus and hold done");
        results();
    end
endmodule // tbss_seq_tb_top
